// ---- ssp_sync_port.sv ----
// synchronous half-duplex serial port: clocking, transmit, receive, flags
`timescale 1ns/1ns
`include "ssp_consts.svh"
module ssp_sync_port #(
    parameter bit PARITY_ODD = 1'b0
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              resetn,
    // control
    input  wire logic [15:0]       serial_control_reg,
    input  wire logic [15:0]       baud_divisor_reg,
    input  wire logic              single_rx_set,
    input  wire logic              single_rx_clr,
    output logic                   single_rx_enable,
    // flags
    output logic                   both_full_flag,
    output logic                   rx_overrun_flag,
    input  wire logic              rx_overrun_clr,
    output logic                   parity_error_flag,
    input  wire logic              parity_error_clr,
    // transmit word in
    input  wire logic              tx_wr_valid,
    output logic                   tx_wr_ready,
    input  wire ssp_pkg::ssp_word_t tx_wr_data,
    // receive word out
    output logic                   rx_rd_valid,
    input  wire logic              rx_rd_ready,
    output ssp_pkg::ssp_word_t     rx_rd_data,
    // events
    output logic                   tx_done_irq,
    output logic                   rx_done_irq,
    // clock pin
    input  wire logic              sclk_i,
    output logic                   sclk_o,
    output logic                   sclk_oe,
    // data pin
    input  wire logic              sdata_i,
    output logic                   sdata_o,
    output logic                   sdata_oe
);
    import ssp_pkg::*;

    // ==========================================================
    // configuration decode
    logic       sync_mode;
    logic       master;
    logic       cont_en;
    logic       par_en;
    logic [1:0] wlen;
    ssp_cnt_t   nbits;
    logic       rx_en;
    logic       tx_allowed;

    assign sync_mode  = serial_control_reg[`SSP_CTL_SYNC]
                        && !serial_control_reg[`SSP_CTL_CODEC];
    assign master     = serial_control_reg[`SSP_CTL_MASTER];
    assign cont_en    = serial_control_reg[`SSP_CTL_CONTINUOUS_RX_ENABLE];
    assign par_en     = serial_control_reg[`SSP_CTL_PAR_EN];
    assign wlen       = serial_control_reg[`SSP_CTL_WLEN_HI:`SSP_CTL_WLEN_LO];
    assign nbits      = ssp_cnt_t'(`SSP_MIN_BITS) + ssp_cnt_t'(wlen) + ssp_cnt_t'(par_en);
    // continuous wins; single only counts in master mode
    assign rx_en      = sync_mode && (cont_en || (master && single_rx_enable));
    assign tx_allowed = sync_mode && !cont_en && !single_rx_enable;

    // frame image: data masked to length, parity above the last data bit
    function automatic logic [9:0] build_frame(input ssp_word_t d, input logic [1:0] wl,
                                               input logic pe);
        logic [9:0] f;
        int         n;
        f = '0;
        n = `SSP_MIN_BITS + int'(wl);
        for (int i = 0; i < 9; i++) begin
            if (i < n) f[i] = d[i];
        end
        if (pe) f[n] = (^f) ^ PARITY_ODD;
        return f;
    endfunction

    // ==========================================================
    // pin synchronisers
    logic sclk_s1_ff;
    logic sclk_s2_ff;
    logic sclk_s3_ff;
    logic sdat_s1_ff;
    logic sdat_s2_ff;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sclk_s1_ff <= 1'b1;
            sclk_s2_ff <= 1'b1;
            sclk_s3_ff <= 1'b1;
            sdat_s1_ff <= 1'b1;
            sdat_s2_ff <= 1'b1;
        end else begin
            sclk_s1_ff <= sclk_i;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_s3_ff <= sclk_s2_ff;
            sdat_s1_ff <= sdata_i;
            sdat_s2_ff <= sdat_s1_ff;
        end
    end

    // ==========================================================
    // master bit clock
    logic [16:0] div_eff;
    logic [16:0] half;
    logic [16:0] div_cnt_ff;
    logic        sclk_ff;
    logic        running;
    logic        m_fall;
    logic        m_rise;
    logic        tx_full_ff;
    logic        rx_in_ready;

    // divisors below the floor are raised so the pin never passes 6.4 MHz
    assign div_eff = ({1'b0, baud_divisor_reg} + 17'h00001 < 17'(`SSP_MIN_DIV))
                     ? 17'(`SSP_MIN_DIV) : {1'b0, baud_divisor_reg} + 17'h00001;
    assign half    = div_eff >> 1;
    assign running = master && ((tx_allowed && tx_full_ff) || (rx_en && rx_in_ready));
    assign m_fall  = running && (div_cnt_ff == half - 17'h00001);
    assign m_rise  = running && (div_cnt_ff == div_eff - 17'h00001);

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            div_cnt_ff <= '0;
            sclk_ff    <= 1'b1;
        end else if (!running) begin
            div_cnt_ff <= '0;
            sclk_ff    <= 1'b1;
        end else begin
            div_cnt_ff <= m_rise ? 17'h00000 : div_cnt_ff + 17'h00001;
            if (m_fall) sclk_ff <= 1'b0;
            if (m_rise) sclk_ff <= 1'b1;
        end
    end

    logic fall_ev;
    logic rise_ev;
    assign fall_ev = sync_mode && (master ? m_fall : (sclk_s3_ff && !sclk_s2_ff));
    assign rise_ev = sync_mode && (master ? m_rise : (!sclk_s3_ff && sclk_s2_ff));

    assign sclk_o  = sclk_ff;
    assign sclk_oe = sync_mode && master;

    // ==========================================================
    // direction state and shared bit counter
    ssp_dir_e dir_ff;
    ssp_dir_e nxt_dir;
    ssp_cnt_t bit_cnt_ff;

    always_comb begin
        case (dir_ff)
            SSP_IDLE: nxt_dir = rx_en ? SSP_RX : (tx_allowed ? SSP_TX : SSP_IDLE);
            SSP_TX:   nxt_dir = tx_allowed ? SSP_TX : SSP_IDLE;
            SSP_RX:   nxt_dir = rx_en ? SSP_RX : SSP_IDLE;
            default:  nxt_dir = SSP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            dir_ff <= SSP_IDLE;
        end else begin
            dir_ff <= nxt_dir;
        end
    end

    // ==========================================================
    // transmit path
    ssp_word_t  tx_hold_ff;
    logic       hold_full_ff;
    logic [9:0] tx_shift_reg;
    logic       tx_wr_take;
    logic       tx_last;

    assign tx_wr_ready = tx_allowed && !(tx_full_ff && hold_full_ff);
    assign tx_wr_take  = tx_wr_valid && tx_wr_ready;
    assign tx_last     = (dir_ff == SSP_TX) && tx_full_ff && rise_ev
                         && (bit_cnt_ff == nbits - 4'h1);

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            tx_hold_ff   <= '0;
            hold_full_ff <= 1'b0;
            tx_full_ff   <= 1'b0;
            tx_shift_reg <= '1;
            tx_done_irq  <= 1'b0;
        end else begin
            tx_done_irq <= tx_last;
            if (!tx_allowed) begin
                tx_full_ff   <= 1'b0;
                hold_full_ff <= 1'b0;
            end else if (tx_last) begin
                if (hold_full_ff || !master) begin
                    tx_shift_reg <= build_frame(tx_hold_ff, wlen, par_en);
                    hold_full_ff <= 1'b0;
                    if (tx_wr_take) begin
                        tx_hold_ff   <= tx_wr_data;
                        hold_full_ff <= 1'b1;
                    end
                end else if (tx_wr_take) begin
                    // a word arriving on the last edge goes straight on, never parked
                    tx_shift_reg <= build_frame(tx_wr_data, wlen, par_en);
                    tx_hold_ff   <= tx_wr_data;
                end else begin
                    tx_full_ff <= 1'b0;
                end
            end else begin
                if (tx_full_ff && rise_ev && dir_ff == SSP_TX) begin
                    tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                end
                if (tx_wr_take && !tx_full_ff) begin
                    tx_shift_reg <= build_frame(tx_wr_data, wlen, par_en);
                    tx_hold_ff   <= tx_wr_data;
                    tx_full_ff   <= 1'b1;
                end else if (tx_wr_take) begin
                    tx_hold_ff   <= tx_wr_data;
                    hold_full_ff <= 1'b1;
                end
            end
        end
    end

    // data pin driven high when nothing is shifting
    assign sdata_o  = tx_full_ff ? tx_shift_reg[0] : 1'b1;
    assign sdata_oe = sync_mode && !cont_en && !single_rx_enable;

    // ==========================================================
    // receive path
    logic [8:0] rx_shift_reg;
    logic       rx_last;
    logic       rx_take;
    logic [8:0] rx_word;
    logic [9:0] rx_frame;
    logic       rx_parity_error_flag;
    logic [9:0] buf_out;
    logic       head_seen_ff;
    logic       head_fresh;

    assign rx_take  = (dir_ff == SSP_RX) && rx_en && fall_ev && rx_in_ready;
    assign rx_last  = rx_take && (bit_cnt_ff == nbits - 4'h1);

    always_comb begin
        rx_frame = {1'b0, rx_shift_reg};
        rx_frame[bit_cnt_ff] = sdat_s2_ff;
        rx_word  = 9'h000;
        for (int i = 0; i < 9; i++) begin
            if (i < `SSP_MIN_BITS + int'(wlen)) rx_word[i] = rx_frame[i];
        end
        rx_parity_error_flag  = par_en && (build_frame(rx_word, wlen, 1'b1) != rx_frame);
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rx_shift_reg <= '0;
            bit_cnt_ff   <= '0;
            rx_done_irq  <= 1'b0;
        end else begin
            rx_done_irq <= rx_last;
            if (dir_ff != nxt_dir || (dir_ff == SSP_RX && !rx_en)) begin
                bit_cnt_ff <= '0;
            end else if (rx_last || tx_last) begin
                bit_cnt_ff <= '0;
            end else if (rx_take || (dir_ff == SSP_TX && tx_full_ff && rise_ev)) begin
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
            if (rx_take) begin
                rx_shift_reg <= rx_frame[8:0];
            end
        end
    end

    ssp_buf2 #(
        .WIDTH (10),
        .DEPTH (2)
    ) u_rx_buf (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .in_valid  (rx_last),
        .in_ready  (rx_in_ready),
        .in_data   ({rx_parity_error_flag, rx_word}),
        .out_valid (rx_rd_valid),
        .out_ready (rx_rd_ready),
        .out_data  (buf_out)
    );

    assign rx_rd_data     = buf_out[8:0];
    assign both_full_flag = !rx_in_ready;
    assign head_fresh     = rx_rd_valid && !head_seen_ff;

    // a word that just became the head reports its own parity
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            head_seen_ff <= 1'b0;
        end else begin
            head_seen_ff <= rx_rd_valid && !rx_rd_ready;
        end
    end

    // ==========================================================
    // sticky flags and single-word enable; a set beats a clear
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rx_overrun_flag   <= 1'b0;
            parity_error_flag <= 1'b0;
            single_rx_enable  <= 1'b0;
        end else begin
            if (rx_en && fall_ev && !rx_in_ready) begin
                rx_overrun_flag <= 1'b1;
            end else if (rx_overrun_clr) begin
                rx_overrun_flag <= 1'b0;
            end
            if (head_fresh && buf_out[9]) begin
                parity_error_flag <= 1'b1;
            end else if (parity_error_clr) begin
                parity_error_flag <= 1'b0;
            end
            if (single_rx_set) begin
                single_rx_enable <= 1'b1;
            end else if (single_rx_clr || (rx_last && master && !cont_en)) begin
                single_rx_enable <= 1'b0;
            end
        end
    end

    // ==========================================================
    // checks
    a_idle_data_high: assert property (@(posedge core_clk) disable iff (!resetn)
        (sdata_oe && !tx_full_ff) |-> sdata_o)
        else $error("data pin not high while idle");
    a_master_clk_idle: assert property (@(posedge core_clk) disable iff (!resetn)
        (sync_mode && master && !running) |=> sclk_o)
        else $error("master clock not high while idle");
    a_tx_blocked_rx: assert property (@(posedge core_clk) disable iff (!resetn)
        (cont_en || single_rx_enable) |-> !tx_wr_ready)
        else $error("transmit accepted while receive enabled");
    a_write_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
        (tx_full_ff && hold_full_ff && !tx_last && tx_allowed) |=> $stable(tx_hold_ff))
        else $error("holding buffer changed while both full");
    a_bbf_blocks: assert property (@(posedge core_clk) disable iff (!resetn)
        both_full_flag |-> !rx_last)
        else $error("word accepted while both full");
    a_ovr_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
        (rx_overrun_flag && !rx_overrun_clr) |=> rx_overrun_flag)
        else $error("overrun flag dropped without clear");
    a_single_done: assert property (@(posedge core_clk) disable iff (!resetn)
        (rx_last && master && !cont_en && !single_rx_set) |=> !single_rx_enable)
        else $error("single enable not cleared after word");
    a_rx_irq_word: assert property (@(posedge core_clk) disable iff (!resetn)
        rx_last |=> (rx_done_irq && rx_rd_valid))
        else $error("received word not signalled");
    a_clk_floor: assert property (@(posedge core_clk) disable iff (!resetn)
        m_rise |-> (div_cnt_ff >= 17'(`SSP_MIN_DIV - 1)))
        else $error("bit clock faster than allowed");
    a_tx_irq_last: assert property (@(posedge core_clk) disable iff (!resetn)
        tx_done_irq |-> $past(rise_ev))
        else $error("transmit interrupt without clock edge");
endmodule

// ---- ssp_consts.svh ----
// constants for the synchronous half-duplex serial port
// What this block does
// - Control bit 13 picks master (drive clock pin) or slave (clock pin is input).
// - Synchronous mode runs when control bit 0 is one and bit 14 zero.
// - Transmit has 9-bit holding buffer and 10-bit shift register, right-aligned words.
// - Idle: data pin driven high; master also holds clock pin high.
// - Transmission allowed only while both receive enables (bits 11, 12) are zero.
// - A write starts transmission; goes to empty shifter at once, else waits.
// - Write while holding buffer and shifter both full is ignored.
// - Master without new word stops data and clock after the last bit.
// - Slave with running clock reloads holding buffer each word, resending it.
// - Bits change on rising edges, LSB first, 6 to 9 bits, optional parity.
// - Transmit interrupt pulses when a word's final bit has gone out.
// - Receive buffer reads right-aligned; bits above word length read zero.
// - Bit 11 enables continuous, bit 12 single-word reception.
// - Receiver samples on falling edges, then moves word to buffer with interrupt.
// - Word completing with holding buffer full sets both-full, further data ignored.
// - Reading the receive buffer clears both-full and advances the waiting word.
// - Data arriving while both-full sets sticky overrun flag, cleared by software.
// - Parity mismatch sets sticky parity flag as the bad word becomes the buffer's head.
// - Master single reception clears its enable after one word; clearing aborts.
// - Continuous wins over single; never cleared by hardware; interrupt every word.
// - In slave mode only the continuous enable starts reception.
// - Word length and parity enable come from control register fields.
// - Master bit clock is core clock divided by divisor plus one.
// - Generated bit clock never exceeds 6.4 MHz.
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
// ==========================================================
// control word fields
`define SSP_CTL_SYNC      0
`define SSP_CTL_WLEN_LO   1
`define SSP_CTL_WLEN_HI   2
`define SSP_CTL_PAR_EN    5
`define SSP_CTL_CONTINUOUS_RX_ENABLE      11
`define SSP_CTL_MASTER    13
`define SSP_CTL_CODEC     14
// ==========================================================
// timing
`define SSP_CLK_KHZ       250000
`define SSP_MAX_SCLK_KHZ  6400
`define SSP_MIN_DIV       ((`SSP_CLK_KHZ + `SSP_MAX_SCLK_KHZ - 1) / `SSP_MAX_SCLK_KHZ)
`define SSP_MIN_BITS      6
`endif

// ---- ssp_pkg.sv ----
// types shared by the serial port files
package ssp_pkg;
    typedef enum logic [2:0] {
        SSP_IDLE = 3'b001,
        SSP_TX   = 3'b010,
        SSP_RX   = 3'b100
    } ssp_dir_e;
    typedef logic [8:0] ssp_word_t;
    typedef logic [3:0] ssp_cnt_t;
endpackage

// ---- ssp_buf2.sv ----
// small FIFO holding received words with their parity mark
`timescale 1ns/1ns
module ssp_buf2 #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             resetn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || WIDTH < 1) $error("ssp_buf2: DEPTH must be >= 2");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            always_ff @(posedge core_clk) begin
                if (!resetn) begin
                    mem_ff[gi] <= '0;
                end else if (push && wr_ptr_ff == AW'(gi)) begin
                    mem_ff[gi] <= in_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

// ---- ssp_far_model.sv ----
// far serial device: slave clock source, data driver, bit catcher
`timescale 1ns/1ns
module ssp_far_model (
    // clock and control
    input  wire logic        core_clk,
    input  wire logic        far_rst_n,
    input  wire logic        clk_run,
    input  wire logic [9:0]  frame,
    input  wire logic [3:0]  nbits,
    // pins of the port
    input  wire logic        sclk_o,
    input  wire logic        sclk_oe,
    input  wire logic        sdata_o,
    input  wire logic        sdata_oe,
    output logic             sclk_i,
    output logic             sdata_i,
    // bits seen on the line
    output logic [15:0]      caught
);
    logic [4:0] div_ff;
    logic       sck_ff;
    logic       prev_ff;
    logic [3:0] idx_ff;
    // ==========================================================
    // clock: idles high, stands still while clk_run is low
    always_ff @(posedge core_clk) begin
        div_ff <= (!clk_run || div_ff == 5'h17) ? 5'h00 : div_ff + 5'h01;
        if (!clk_run) sck_ff <= 1'b1;
        else if (div_ff == 5'h17) sck_ff <= ~sck_ff;
    end
    // ==========================================================
    // line levels: whoever has the enable wins
    assign sclk_i  = sclk_oe ? sclk_o : sck_ff;
    assign sdata_i = sdata_oe ? sdata_o : frame[idx_ff];
    // next bit after each rising edge, catch on falling edges
    always_ff @(posedge core_clk) begin
        prev_ff <= far_rst_n ? sclk_i : 1'b1;
        if (!far_rst_n) idx_ff <= 4'h0;
        else if (sclk_i && !prev_ff) idx_ff <= (idx_ff + 4'h1 == nbits) ? 4'h0 : idx_ff + 4'h1;
        if (!sclk_i && prev_ff) caught <= {sdata_i, caught[15:1]};
    end
endmodule

// ---- tb_top.sv ----
// self-checking bench for the synchronous serial port
`timescale 1ns/1ns
module tb_top;
    import ssp_pkg::*;
    // ==========================================================
    // signals
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [15:0] ctl = 16'h0000;
    logic [15:0] kdiv = 16'h0030;
    logic        srx_set = 1'b0, ov_clr = 1'b0, pe_clr = 1'b0, wr_v = 1'b0, rd_r = 1'b0;
    logic        run = 1'b0, frst = 1'b0, srx_clr = 1'b0;
    ssp_word_t   wr_d = 9'h000;
    ssp_word_t   w0, w1, rd_d;
    logic [9:0]  frame = 10'h000;
    logic [3:0]  nb = 4'h6;
    logic [15:0] caught;
    logic        srx_en, bff, ovf, pef, wr_rdy, rd_v, sco, scoe, sdo, sdoe, sci, sdi, txi, rxi;
    int          fails = 0;
    int          tests_run = 0;
    always #2 core_clk = ~core_clk;
    ssp_sync_port #(.PARITY_ODD(1'b0)) dut_u (
        .core_clk(core_clk), .resetn(resetn), .serial_control_reg(ctl),
        .baud_divisor_reg(kdiv), .single_rx_set(srx_set), .single_rx_clr(srx_clr),
        .single_rx_enable(srx_en), .both_full_flag(bff), .rx_overrun_flag(ovf),
        .rx_overrun_clr(ov_clr), .parity_error_flag(pef), .parity_error_clr(pe_clr),
        .tx_wr_valid(wr_v), .tx_wr_ready(wr_rdy), .tx_wr_data(wr_d),
        .rx_rd_valid(rd_v), .rx_rd_ready(rd_r), .rx_rd_data(rd_d),
        .tx_done_irq(txi), .rx_done_irq(rxi), .sclk_i(sci), .sclk_o(sco),
        .sclk_oe(scoe), .sdata_i(sdi), .sdata_o(sdo), .sdata_oe(sdoe));
    ssp_far_model far_u (
        .core_clk(core_clk), .far_rst_n(frst), .clk_run(run), .frame(frame),
        .nbits(nb), .sclk_o(sco), .sclk_oe(scoe), .sdata_o(sdo),
        .sdata_oe(sdoe), .sclk_i(sci), .sdata_i(sdi), .caught(caught));
    // ==========================================================
    // helpers
    function automatic logic [15:0] cfg(bit m, bit c, logic [1:0] wl, bit p);
        cfg = 16'h0001;
        cfg[13] = m;
        cfg[11] = c;
        cfg[2:1] = wl;
        cfg[5] = p;
    endfunction
    // even parity lands just above the data bits
    function automatic logic [9:0] frm(ssp_word_t d, int n, bit p);
        frm = {1'b0, d} & ((10'h001 << n) - 10'h001);
        if (p) frm[n] = ^frm;
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // 0 tx done, 1 rx valid, 2 both full, 3 overrun
    task automatic wt(input int w, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge core_clk);
            #1;
            if ((w == 0 && txi === 1'b1) || (w == 1 && rd_v === 1'b1)) break;
            if ((w == 2 && bff === 1'b1) || (w == 3 && ovf === 1'b1)) break;
        end
        if (i == lim) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic rst(input logic [15:0] c, input logic [9:0] f, input logic [3:0] n);
        @(posedge core_clk);
        resetn <= 1'b0;
        frst <= 1'b0;
        run <= 1'b0;
        ctl <= c;
        frame <= f;
        nb <= n;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        frst <= 1'b1;
    endtask
    task automatic pop();
        @(posedge core_clk);
        rd_r <= 1'b1;
        @(posedge core_clk);
        rd_r <= 1'b0;
    endtask
    // ==========================================================
    // scenarios
    initial begin
        void'($urandom(30));
        @(posedge core_clk);
        kdiv <= 16'($urandom_range(63, 40));
        w0 = 9'($urandom) & 9'h0FF;
        w1 = 9'($urandom) & 9'h0FF;
        rst(cfg(1'b1, 1'b0, 2'h2, 1'b1), 10'h000, 4'h9);
        #1;
        chk(sco, 1'b1);
        chk(scoe, 1'b1);
        chk(sdoe, 1'b1);
        // back-to-back writes, the third one while both stages are full
        @(posedge core_clk);
        wr_v <= 1'b1;
        wr_d <= w0;
        @(posedge core_clk);
        wr_d <= w1;
        @(posedge core_clk);
        wr_d <= 9'h155;
        #1;
        chk(wr_rdy, 1'b0);
        @(posedge core_clk);
        wr_v <= 1'b0;
        wt(0, 800);
        chk(caught >> 7, frm(w0, 8, 1'b1));
        wt(0, 800);
        chk(caught >> 7, frm(w1, 8, 1'b1));
        repeat (300) @(posedge core_clk);
        #1;
        chk(sco, 1'b1);
        chk(sdo, 1'b1);
        @(posedge core_clk);
        ctl <= cfg(1'b1, 1'b1, 2'h2, 1'b1);
        repeat (2) @(posedge core_clk);
        #1;
        chk(wr_rdy, 1'b0);
        // codec bit set: the synchronous port must let go of the clock pin and refuse writes
        @(posedge core_clk);
        ctl <= cfg(1'b1, 1'b0, 2'h2, 1'b1) | 16'h4000;
        repeat (2) @(posedge core_clk);
        #1;
        chk(scoe, 1'b0);
        chk(wr_rdy, 1'b0);
        // continuous master reception, 6 bits with parity
        w0 = w0 & 9'h03F;
        rst(cfg(1'b1, 1'b1, 2'h0, 1'b1), frm(w0, 6, 1'b1), 4'h7);
        repeat (2) begin
            wt(1, 2000);
            chk(rd_d, w0);
            chk(pef, 1'b0);
            pop();
        end
        // bad parity on every word
        rst(cfg(1'b1, 1'b1, 2'h0, 1'b1), frm(w0, 6, 1'b1) ^ 10'h040, 4'h7);
        wt(1, 2000);
        repeat (2) @(posedge core_clk);
        #1;
        chk(pef, 1'b1);
        @(posedge core_clk);
        pe_clr <= 1'b1;
        @(posedge core_clk);
        pe_clr <= 1'b0;
        wt(2, 1000);
        chk(pef, 1'b0);
        pop();
        repeat (3) @(posedge core_clk);
        #1;
        chk(pef, 1'b1);
        chk(bff, 1'b0);
        // slave: single enable does nothing, then overrun
        w1 = w1 & 9'h03F;
        rst(cfg(1'b0, 1'b0, 2'h0, 1'b0), frm(w1, 6, 1'b0), 4'h6);
        srx_set <= 1'b1;
        run <= 1'b1;
        @(posedge core_clk);
        srx_set <= 1'b0;
        repeat (600) @(posedge core_clk);
        #1;
        chk(rd_v, 1'b0);
        rst(cfg(1'b0, 1'b1, 2'h0, 1'b0), frm(w1, 6, 1'b0), 4'h6);
        run <= 1'b1;
        wt(2, 2000);
        chk(rd_d, w1);
        wt(3, 200);
        @(posedge core_clk);
        run <= 1'b0;
        pop();
        #1;
        chk(ovf, 1'b1);
        @(posedge core_clk);
        ov_clr <= 1'b1;
        @(posedge core_clk);
        ov_clr <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk(bff, 1'b0);
        chk(ovf, 1'b0);
        // master single word, 7 bits
        rst(cfg(1'b1, 1'b0, 2'h1, 1'b0), frm(w0, 7, 1'b0), 4'h7);
        kdiv <= 16'h0004;
        srx_set <= 1'b1;
        @(posedge core_clk);
        srx_set <= 1'b0;
        wt(1, 2000);
        chk(rxi, 1'b1);
        chk(rd_d, w0);
        repeat (300) @(posedge core_clk);
        #1;
        chk(srx_en, 1'b0);
        chk(sco, 1'b1);
        // clearing the single enable in mid-word drops that word
        pop();
        srx_set <= 1'b1;
        @(posedge core_clk);
        srx_set <= 1'b0;
        repeat (100) @(posedge core_clk);
        srx_clr <= 1'b1;
        @(posedge core_clk);
        srx_clr <= 1'b0;
        repeat (300) @(posedge core_clk);
        #1;
        chk(rd_v, 1'b0);
        chk(sco, 1'b1);
        // slave transmit: word loaded before the clock, then resent
        rst(cfg(1'b0, 1'b0, 2'h0, 1'b0), 10'h000, 4'h6);
        wr_v <= 1'b1;
        wr_d <= w1;
        @(posedge core_clk);
        wr_v <= 1'b0;
        run <= 1'b1;
        wt(0, 1000);
        wt(0, 1000);
        chk(caught >> 4, {w1[5:0], w1[5:0]});
        give_verdict();
    end
endmodule
